// File: include/timer2_defines.svh
`ifndef TIMER2_DEFINES_SVH
`define TIMER2_DEFINES_SVH

// ---------------------------------------------------------------
// count layout
// ---------------------------------------------------------------
`define COUNT_WIDTH 16
`define HALF_WIDTH 8
`define COUNT_MAX 16'hffff
`define COUNT_RESET 16'h0000
`define RELOAD_RESET 16'h0000

// ---------------------------------------------------------------
// timing counts, in core_clk cycles
// ---------------------------------------------------------------
`define TIMER_DIV 12
`define FAST_DIV 2
`define PRESCALE_WIDTH 4

// ---------------------------------------------------------------
// pin reset levels
// ---------------------------------------------------------------
`define CLKOUT_RESET 1'b1
`define PIN_IDLE 1'b1

`endif

// File: include/timer2_pkg.sv
// ---------------------------------------------------------------
// shared types
// ---------------------------------------------------------------
`default_nettype none
package timer2_pkg;

  typedef struct packed {
    logic rx_clock_select;
    logic tx_clock_select;
    logic capture_reload_select;
    logic counter_select;
    logic run_control;
    logic external_event_enable;
    logic direction_enable;
    logic clock_out_enable;
  } ctrl_t;

  typedef struct packed {
    logic count_we;
    logic reload_we;
    logic [15:0] data;
  } sw_write_t;

  typedef struct packed {
    logic overflow_clear;
    logic external_clear;
  } flag_clear_t;

  typedef enum logic [2:0] {
    MODE_CAPTURE,
    MODE_RELOAD,
    MODE_UPDOWN,
    MODE_BAUD
  } mode_t;

endpackage : timer2_pkg

`default_nettype wire

// File: logic/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
`include "timer2_defines.svh"

module pin_sync
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pin,
  output logic level,
  output logic fall
);

  // ---------------------------------------------------------------
  // three-stage sampler, change taken once stages two and three agree
  // ---------------------------------------------------------------
  logic s1;
  logic s2;
  logic s3;
  logic next_level;
  logic next_fall;

  always_comb
  begin
    next_level = level;
    next_fall = 1'b0;
    if (s2 == s3)
    begin
      next_level = s3;
      next_fall = level & ~s3;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s1 <= `PIN_IDLE;
      s2 <= `PIN_IDLE;
      s3 <= `PIN_IDLE;
      level <= `PIN_IDLE;
      fall <= 1'b0;
    end
    else
    begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      level <= next_level;
      fall <= next_fall;
    end
  end

endmodule : pin_sync

`default_nettype wire

// File: logic/timer2_updown_clockout.sv
`timescale 1ns/1ns
`default_nettype none
`include "timer2_defines.svh"

// Behaviour
// R01: the 16-bit count is a low byte cascaded into a high byte.
// R02: counter select picks the clock divided by 12 or the external count pin.
// R03: the count advances only while run control is set.
// R04: capture, auto-reload and baud modes follow the clock selects and capture/reload select.
// R05: with direction enable set, auto-reload counts up or down by the direction pin.
// R06: counting up, passing ffff sets the overflow flag, requests interrupt and loads the reload; the code loads 0000 in capture mode.
// R07: counting down, reaching the reload value sets the overflow flag and loads ffff.
// R08: in up/down mode the external flag toggles on each wrap and raises no interrupt.
// R09: in clock-out mode the count advances at half the clock rate and reloads on overflow.
// R10: clock-out drives a 50% square wave of clock over 4 times (65536 minus reload).
// R11: clock-out overflows never request an interrupt.
// R12: software sets clock-out enable, clears counter select, loads reload, count, then runs.
// R13: baud generation and clock-out may run together on the same reload pair.
// R14: overflow flag is set only with both serial clock selects clear and only software clears it.
// R15: with external enable and no baud use, a direction pin fall captures or reloads and sets the external flag; the code also ignores it in up/down mode.
// R16: counter operation counts falling edges of the count pin; clock-out needs counter select clear.
// R17: external pins are synchronised and edges found from successive samples.

module timer2_updown_clockout
(
  input wire logic core_clk,
  input wire logic rst,
  input wire timer2_pkg::ctrl_t ctrl,
  input wire timer2_pkg::sw_write_t sw_write,
  input wire timer2_pkg::flag_clear_t flag_clear,
  input wire logic count_input_pin_in,
  output logic count_input_pin_out,
  output logic count_input_pin_oe,
  input wire logic direction_capture_pin_in,
  output logic [15:0] count,
  output logic [15:0] reload,
  output logic overflow_flag,
  output logic external_flag,
  output logic interrupt_request,
  output logic baud_tick
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic cnt_level;
  logic cnt_fall;
  logic dir_level;
  logic dir_fall;

  pin_sync u_cnt_sync
  (
    .core_clk(core_clk),
    .rst(rst),
    .pin(count_input_pin_in),
    .level(cnt_level),
    .fall(cnt_fall)
  ); // R17

  pin_sync u_dir_sync
  (
    .core_clk(core_clk),
    .rst(rst),
    .pin(direction_capture_pin_in),
    .level(dir_level),
    .fall(dir_fall)
  ); // R17

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  timer2_pkg::mode_t mode;
  logic clkout_mode;
  logic fast_rate;

  assign mode = (ctrl.rx_clock_select | ctrl.tx_clock_select) ? timer2_pkg::MODE_BAUD // R04
    : ctrl.capture_reload_select ? timer2_pkg::MODE_CAPTURE // R04
    : ctrl.direction_enable ? timer2_pkg::MODE_UPDOWN // R05
    : timer2_pkg::MODE_RELOAD;

  // clock-out only with internal clocking
  assign clkout_mode = ctrl.clock_out_enable & ~ctrl.counter_select; // R16
  assign fast_rate = clkout_mode | (mode == timer2_pkg::MODE_BAUD); // R13
  assign count_input_pin_oe = clkout_mode;

  // ---------------------------------------------------------------
  // count tick generation
  // ---------------------------------------------------------------
  logic [`PRESCALE_WIDTH-1:0] presc;
  logic half;
  logic [`PRESCALE_WIDTH-1:0] next_presc;
  logic next_half;
  logic tick;

  always_comb
  begin
    next_presc = presc;
    next_half = half;
    tick = 1'b0;
    if (ctrl.run_control)
    begin
      if (fast_rate)
      begin
        next_half = ~half;
        tick = half; // R09
      end
      else if (ctrl.counter_select)
      begin
        tick = cnt_fall; // R16
      end
      else
      begin
        tick = (presc == `PRESCALE_WIDTH'(`TIMER_DIV - 1)); // R02
        next_presc = tick ? '0 : presc + `PRESCALE_WIDTH'(1);
      end
    end
  end // R03

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      presc <= '0;
      half <= 1'b0;
    end
    else
    begin
      presc <= next_presc;
      half <= next_half;
    end
  end

  // ---------------------------------------------------------------
  // count, reload, flags and clock-out pin
  // ---------------------------------------------------------------
  logic counting_up;
  logic wrap;
  logic ext_event;
  logic [7:0] low_plus;
  logic carry;
  logic [15:0] next_count;
  logic [15:0] next_reload;
  logic next_overflow;
  logic next_external;
  logic next_pin_out;
  logic next_baud_tick;

  assign counting_up = (mode != timer2_pkg::MODE_UPDOWN) | dir_level; // R05
  assign wrap = tick & (counting_up ? (count == `COUNT_MAX) : (count == reload)); // R06 R07
  assign ext_event = ctrl.external_event_enable & dir_fall
    & (mode != timer2_pkg::MODE_BAUD) & (mode != timer2_pkg::MODE_UPDOWN); // R15
  assign low_plus = count[7:0] + 8'h01;
  assign carry = (count[7:0] == 8'hff); // R01

  always_comb
  begin
    next_count = count;
    next_reload = reload;
    next_overflow = overflow_flag;
    next_external = external_flag;
    next_pin_out = count_input_pin_out;
    next_baud_tick = 1'b0;
    if (flag_clear.overflow_clear)
    begin
      next_overflow = 1'b0;
    end
    if (flag_clear.external_clear)
    begin
      next_external = 1'b0;
    end
    if (wrap)
    begin
      if (!counting_up)
      begin
        next_count = `COUNT_MAX; // R07
      end
      else if (mode == timer2_pkg::MODE_CAPTURE)
      begin
        next_count = `COUNT_RESET;
      end
      else
      begin
        next_count = reload; // R06 R09
      end
      if (mode == timer2_pkg::MODE_BAUD)
      begin
        next_baud_tick = 1'b1;
      end
      else if (!clkout_mode)
      begin
        next_overflow = 1'b1; // R14 R11
      end
      if (mode == timer2_pkg::MODE_UPDOWN)
      begin
        next_external = ~next_external; // R08
      end
      if (clkout_mode)
      begin
        next_pin_out = ~count_input_pin_out; // R10
      end
    end
    else if (tick)
    begin
      if (counting_up)
      begin
        next_count = {count[15:8] + {7'h00, carry}, low_plus}; // R01
      end
      else
      begin
        next_count = count - 16'h0001; // R05
      end
    end
    if (ext_event)
    begin
      next_external = 1'b1; // R15
      if (mode == timer2_pkg::MODE_CAPTURE)
      begin
        next_reload = count;
      end
      else
      begin
        next_count = reload;
      end
    end
    if (sw_write.count_we)
    begin
      next_count = sw_write.data;
    end
    if (sw_write.reload_we)
    begin
      next_reload = sw_write.data;
    end
    if (!clkout_mode)
    begin
      next_pin_out = `CLKOUT_RESET;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      count <= `COUNT_RESET;
      reload <= `RELOAD_RESET;
      overflow_flag <= 1'b0;
      external_flag <= 1'b0;
      count_input_pin_out <= `CLKOUT_RESET;
      baud_tick <= 1'b0;
    end
    else
    begin
      count <= next_count;
      reload <= next_reload;
      overflow_flag <= next_overflow;
      external_flag <= next_external;
      count_input_pin_out <= next_pin_out;
      baud_tick <= next_baud_tick;
    end
  end

  // external flag interrupts only while direction enable is clear
  assign interrupt_request = overflow_flag
    | (external_flag & ~ctrl.direction_enable); // R08 R11

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  logic quiet;
  assign quiet = ~sw_write.count_we & ~ext_event;

  sequence s_wrap_up;
    wrap && counting_up && quiet && mode != timer2_pkg::MODE_CAPTURE;
  endsequence

  sequence s_wrap_down;
    wrap && !counting_up && quiet;
  endsequence

  sequence s_clkout_wrap;
    wrap && clkout_mode;
  endsequence

  a_run_stop_hold: assert property ( // R03
    !ctrl.run_control && quiet |=> count == $past(count))
    else $error("count moved while stopped");
  a_timer_tick_rate: assert property ( // R02
    tick && !fast_rate && !ctrl.counter_select
    && $stable(ctrl) |=> !tick [*8])
    else $error("timer tick faster than divide by 12");
  a_counter_edge: assert property ( // R16
    ctrl.run_control && ctrl.counter_select && !fast_rate && cnt_fall && counting_up
    && !wrap && quiet |=> count == $past(count) + 16'h0001)
    else $error("counter tick not tied to pin fall");
  a_low_high_cascade: assert property ( // R01
    tick && !wrap && counting_up && carry && quiet
    |=> count[15:8] == $past(count[15:8]) + 8'h01 && count[7:0] == 8'h00)
    else $error("carry into high byte lost");
  a_up_overflow_reload: assert property ( // R06
    s_wrap_up |=> count == $past(reload))
    else $error("up overflow did not reload");
  a_up_overflow_flag: assert property ( // R14
    (s_wrap_up and (mode != timer2_pkg::MODE_BAUD && !clkout_mode))
    |=> overflow_flag && interrupt_request)
    else $error("overflow flag not set");
  a_down_underflow: assert property ( // R07
    s_wrap_down |=> count == `COUNT_MAX && overflow_flag == !$past(clkout_mode)
    || $past(clkout_mode))
    else $error("underflow did not load ffff");
  a_updown_toggle: assert property ( // R08
    wrap && mode == timer2_pkg::MODE_UPDOWN && !flag_clear.external_clear
    |=> external_flag != $past(external_flag))
    else $error("external flag did not toggle");
  a_clkout_no_irq: assert property ( // R11
    s_clkout_wrap |=> !$rose(overflow_flag))
    else $error("clock-out overflow raised a flag");
  a_clkout_toggle: assert property ( // R10
    s_clkout_wrap ##1 clkout_mode |-> count_input_pin_out != $past(count_input_pin_out))
    else $error("clock-out pin did not toggle");
  a_baud_no_flag: assert property ( // R14
    wrap && mode == timer2_pkg::MODE_BAUD |=> !$rose(overflow_flag) && baud_tick)
    else $error("baud overflow set the flag");
  a_flag_sticky: assert property ( // R14
    overflow_flag && !flag_clear.overflow_clear |=> overflow_flag)
    else $error("overflow flag dropped without clear");
  a_ext_capture: assert property ( // R15
    ext_event && mode == timer2_pkg::MODE_CAPTURE && !sw_write.reload_we
    |=> external_flag && reload == $past(count))
    else $error("external capture missed");

endmodule : timer2_updown_clockout

`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef struct {
    logic [7:0] c;
    int sp;
    logic [15:0] wrap;
    logic of;
    logic ex;
    logic bt;
  } row_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  timer2_pkg::ctrl_t ctrl = '0;
  timer2_pkg::sw_write_t sw_write = '0;
  timer2_pkg::flag_clear_t flag_clear = '0;
  logic cnt_pin = 1'b1;
  logic dir_pin = 1'b1;
  logic pin_out;
  logic pin_oe;
  logic [15:0] count;
  logic [15:0] reload;
  logic overflow_flag;
  logic external_flag;
  logic irq;
  logic baud_tick;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  int n;
  logic seen;
  logic old1;
  logic [15:0] old;
  // ctrl bits msb..lsb: rx tx capture counter run ext dir clkout
  row_t rows[7] = '{
    '{8'h08, 12, 16'h1234, 1'b1, 1'b0, 1'b0},
    '{8'h28, 12, 16'h0000, 1'b1, 1'b0, 1'b0},
    '{8'h48, 2, 16'h1234, 1'b0, 1'b0, 1'b1},
    '{8'h88, 2, 16'h1234, 1'b0, 1'b0, 1'b1},
    '{8'h09, 2, 16'h1234, 1'b0, 1'b0, 1'b0},
    '{8'h49, 2, 16'h1234, 1'b0, 1'b0, 1'b1},
    '{8'h0a, 12, 16'h1234, 1'b1, 1'b1, 1'b0}
  };

  timer2_updown_clockout i_timer2_updown_clockout
  (
    .core_clk(core_clk),
    .rst(rst),
    .ctrl(ctrl),
    .sw_write(sw_write),
    .flag_clear(flag_clear),
    .count_input_pin_in(cnt_pin),
    .count_input_pin_out(pin_out),
    .count_input_pin_oe(pin_oe),
    .direction_capture_pin_in(dir_pin),
    .count(count),
    .reload(reload),
    .overflow_flag(overflow_flag),
    .external_flag(external_flag),
    .interrupt_request(irq),
    .baud_tick(baud_tick)
  );

  always #5 core_clk = ~core_clk;

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      bad_count++;
      results();
    end
  end

  task automatic check_value(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_value

  task automatic check_bit(input logic got, input logic exp);
    check_value({15'h0000, got}, {15'h0000, exp});
  endtask : check_bit

  // baud pulses are caught at each falling edge
  task automatic step(input int k);
    repeat (k)
    begin
      @(negedge core_clk);
      if (baud_tick === 1'b1)
        seen = 1'b1;
    end
  endtask : step

  task automatic wr(input logic c, input logic [15:0] d);
    sw_write = {c, ~c, d};
    step(1);
    sw_write = '0;
    step(1);
  endtask : wr

  task automatic wait_change();
    old = count;
    n = 0;
    while (count === old && n < 2000)
    begin
      step(1);
      n++;
    end
  endtask : wait_change

  task automatic do_reset();
    ctrl = '0;
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    seen = 1'b0;
  endtask : do_reset

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial
  begin
    seen = 1'b0;
    step(10);
    rst = 1'b0;
    check_value(count, 16'h0000);
    check_value(reload, 16'h0000);
    check_bit(pin_out, 1'b1);
    check_bit(irq, 1'b0);
    $display("test reset done");
    foreach (rows[i])
    begin
      do_reset();
      ctrl = rows[i].c & 8'hf7;
      wr(1'b0, 16'h1234);
      wr(1'b1, 16'hfffe);
      ctrl = rows[i].c;
      wait_change();
      check_value(count, 16'hffff);
      wait_change();
      check_value(16'(n), 16'(rows[i].sp));
      check_value(count, rows[i].wrap);
      check_bit(overflow_flag, rows[i].of);
      check_bit(external_flag, rows[i].ex);
      check_bit(irq, rows[i].of);
      check_bit(seen, rows[i].bt);
      check_bit(pin_oe, rows[i].c[0]);
      ctrl = '0;
      flag_clear = '{1'b1, 1'b1};
      step(1);
      flag_clear = '0;
      step(1);
      check_bit(overflow_flag, 1'b0);
      $display("test mode row %0d done", i);
    end
    do_reset();
    wr(1'b1, 16'h00fe);
    ctrl = 8'h08;
    wait_change();
    wait_change();
    check_value(count, 16'h0100);
    ctrl = '0;
    step(2);
    old = count;
    step(40);
    check_value(count, old);
    $display("test freeze done");
    do_reset();
    dir_pin = 1'b0;
    step(6);
    wr(1'b0, 16'h1234);
    wr(1'b1, 16'h1236);
    ctrl = 8'h0a;
    wait_change();
    check_value(count, 16'h1235);
    wait_change();
    wait_change();
    check_value(count, 16'hffff);
    check_bit(overflow_flag, 1'b1);
    check_bit(external_flag, 1'b1);
    $display("test down count done");
    do_reset();
    dir_pin = 1'b1;
    wr(1'b1, 16'h0000);
    ctrl = 8'h18;
    repeat (3)
    begin
      cnt_pin = 1'b0;
      step(8);
      cnt_pin = 1'b1;
      step(8);
    end
    check_value(count, 16'h0003);
    $display("test counter done");
    do_reset();
    ctrl = 8'h01;
    wr(1'b0, 16'hfff0);
    wr(1'b1, 16'hfff0);
    ctrl = 8'h09;
    for (int k = 0; k < 4; k++)
    begin
      old1 = pin_out;
      n = 0;
      while (pin_out === old1 && n < 500)
      begin
        step(1);
        n++;
      end
      if (k > 0)
        check_value(16'(n), 16'h0020);
    end
    check_bit(overflow_flag, 1'b0);
    $display("test clock out done");
    do_reset();
    wr(1'b0, 16'h0100);
    wr(1'b1, 16'h0042);
    ctrl = 8'h04;
    dir_pin = 1'b0;
    step(8);
    check_value(count, 16'h0100);
    check_bit(external_flag, 1'b1);
    check_bit(irq, 1'b1);
    flag_clear = '{1'b0, 1'b1};
    step(1);
    flag_clear = '0;
    step(1);
    check_bit(external_flag, 1'b0);
    ctrl = 8'h24;
    dir_pin = 1'b1;
    step(6);
    wr(1'b1, 16'h0077);
    dir_pin = 1'b0;
    step(8);
    check_value(reload, 16'h0077);
    $display("test external event done");
    results();
  end
endmodule : testbench
`default_nettype wire
